// *** include/convert_compare_pkg.sv ***
package convert_compare_pkg;

	// ************************************************************
	// operation codes
	// ************************************************************
	localparam logic [7:0] OPC_FLOAT_FLAGS = 8'h82; // 130, probe, mode from status
	localparam logic [7:0] OPC_FLOAT_RZ = 8'h75; // 117, truncating convert
	localparam logic [7:0] OPC_FLOAT_RZ_FLAGS = 8'h76; // 118, truncating probe
	localparam logic [7:0] OPC_GEQ = 8'h0E; // 14, signed compare

	// ************************************************************
	// latencies in cycles from issue edge to write edge
	// ************************************************************
	localparam int FLOAT_LATENCY = 3;
	localparam int COMPARE_LATENCY = 1;

	// ************************************************************
	// exception field layout, same for status word and probes
	// ************************************************************
	localparam int EXC_WIDTH = 6;
	localparam int EXC_INEXACT_BIT = 1; // value 0x02
	localparam int EXC_INVALID_BIT = 4; // value 0x10
	localparam int EXC_FLUSH_BIT = 5; // value 0x20
	localparam logic [5:0] EXC_RESET = 6'h00;

	// ************************************************************
	// rounding mode field of the status word
	// ************************************************************
	localparam logic [1:0] RM_NEAREST_EVEN = 2'h0;
	localparam logic [1:0] RM_TOWARD_ZERO = 2'h1;
	localparam logic [1:0] RM_TOWARD_POS = 2'h2;
	localparam logic [1:0] RM_TOWARD_NEG = 2'h3;

	// ************************************************************
	// single precision layout
	// ************************************************************
	localparam int FP_MANT_WIDTH = 23;
	localparam int FP_EXP_BIAS = 127;

	// kind of float operation riding the pipeline
	typedef enum logic [1:0] {
		FOP_CONVERT,
		FOP_PROBE
	} float_op_t;

endpackage

// *** hdl/int_to_single_round.sv ***
`timescale 1ns/10ps
// ************************************************************
// signed 32-bit integer to single precision, combinational
// ************************************************************
module int_to_single_round
(
	input wire logic [31:0] value,
	input wire logic [1:0] mode,
	output logic [31:0] result,
	output logic inexact
);

	// leading zero count of a nonzero magnitude
	function automatic logic [4:0] lead_zeros(input logic [31:0] x);
		logic [4:0] n;
		logic found;
		n = 5'h00;
		found = 1'b0;
		for (int i = 31; i >= 0; i--)
		begin
			if (!found && x[i])
			begin
				found = 1'b1;
				n = 5'(31 - i);
			end
		end
		return n;
	endfunction

	logic sign; // sign of the integer
	logic [31:0] magnitude; // -2^31 still fits unsigned
	logic [4:0] shift; // normalising shift
	logic [31:0] normal; // leading one at bit 31
	logic round_bit; // first dropped bit
	logic sticky; // any lower dropped bit
	logic round_up; // add one ulp
	logic [7:0] exponent; // biased exponent
	logic [30:0] rounded; // exponent and mantissa after rounding

	// normalise, then round in the selected mode
	always_comb
	begin
		sign = value[31];
		magnitude = sign ? 32'(-value) : value;
		shift = lead_zeros(magnitude);
		normal = magnitude << shift;
		round_bit = normal[7];
		sticky = |normal[6:0];
		inexact = round_bit | sticky;
		exponent = 8'(convert_compare_pkg::FP_EXP_BIAS + 31 - int'(shift));
		unique case (mode)
			convert_compare_pkg::RM_NEAREST_EVEN: round_up = round_bit & (sticky | normal[8]);
			convert_compare_pkg::RM_TOWARD_ZERO: round_up = 1'b0;
			convert_compare_pkg::RM_TOWARD_POS: round_up = !sign & inexact;
			convert_compare_pkg::RM_TOWARD_NEG: round_up = sign & inexact;
		endcase
		// a carry out of the mantissa bumps the exponent for free
		rounded = {exponent, normal[30:8]} + {30'h00000000, round_up};
		if (magnitude == 32'h00000000)
			result = 32'h00000000;
		else
			result = {sign, rounded};
	end

endmodule

// *** hdl/sticky_exception_bits.sv ***
`timescale 1ns/10ps
// ************************************************************
// sticky exception field of the status word
// ************************************************************
module sticky_exception_bits
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [5:0] own_set,
	input wire logic [5:0] other_set,
	input wire logic write_enable,
	input wire logic [5:0] write_data,
	output logic [5:0] bits
);

	logic [5:0] next_bits; // value after this edge

	// explicit write is the only clear; sets in the same cycle still win
	always_comb
	begin
		if (write_enable)
			next_bits = write_data | own_set | other_set;
		else
			next_bits = bits | own_set | other_set;
	end

	// register the field
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			bits <= convert_compare_pkg::EXC_RESET;
		else
			bits <= next_bits;
	end

endmodule

// *** hdl/int_to_float_convert_and_compare.sv ***
`timescale 1ns/10ps
// ************************************************************
// convert, flag probe and signed compare datapath
// ************************************************************
module int_to_float_convert_and_compare
#(
	parameter int DEST_WIDTH = 7
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic issue_valid,
	input wire logic [7:0] issue_opcode,
	input wire logic [DEST_WIDTH-1:0] issue_dest,
	input wire logic guard_enable,
	input wire logic [31:0] guard_value,
	input wire logic [31:0] first_source,
	input wire logic [31:0] second_source,
	input wire logic [1:0] rounding_mode,
	input wire logic status_write,
	input wire logic [5:0] status_write_data,
	input wire logic [5:0] other_fp_flags,
	output logic float_write,
	output logic [DEST_WIDTH-1:0] float_dest,
	output logic [31:0] float_data,
	output logic compare_write,
	output logic [DEST_WIDTH-1:0] compare_dest,
	output logic [31:0] compare_data,
	output logic [5:0] exception_flags
);

	// ************************************************************
	// elaboration checks
	// ************************************************************
	// a zero-width destination index would leave nothing to address
	if (DEST_WIDTH < 1)
		$error("DEST_WIDTH must be at least one");

	// ************************************************************
	// reset release
	// ************************************************************
	logic [1:0] reset_pipe; // two-stage release chain
	logic reset_sync_n; // released copy used everywhere below

	// assert at once, release two edges later
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			reset_pipe <= 2'h0;
		else
			reset_pipe <= {reset_pipe[0], 1'b1};
	end

	assign reset_sync_n = reset_pipe[1];

	// ************************************************************
	// issue decode
	// ************************************************************
	logic guard_true; // guard absent or its lsb set
	logic is_float_op; // one of the three float unit ops
	logic is_compare_op; // signed compare
	convert_compare_pkg::float_op_t issue_kind; // convert or probe
	logic [1:0] issue_mode; // rounding mode carried down the pipe

	// unknown opcodes match nothing and are dropped silently
	always_comb
	begin
		guard_true = !guard_enable || guard_value[0];
		is_float_op = 1'b0;
		is_compare_op = 1'b0;
		issue_kind = convert_compare_pkg::FOP_PROBE;
		issue_mode = convert_compare_pkg::RM_TOWARD_ZERO;
		unique case (issue_opcode)
			convert_compare_pkg::OPC_FLOAT_FLAGS:
			begin
				is_float_op = 1'b1;
				issue_mode = rounding_mode;
			end
			convert_compare_pkg::OPC_FLOAT_RZ:
			begin
				is_float_op = 1'b1;
				// status rounding bits ignored
				issue_kind = convert_compare_pkg::FOP_CONVERT;
			end
			convert_compare_pkg::OPC_FLOAT_RZ_FLAGS:
			begin
				is_float_op = 1'b1;
			end
			convert_compare_pkg::OPC_GEQ:
			begin
				is_compare_op = 1'b1;
			end
			default:
			begin
				is_float_op = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// compare path, one cycle
	// ************************************************************
	logic next_compare_write; // write strobe at next edge
	logic [DEST_WIDTH-1:0] next_compare_dest; // destination index
	logic [31:0] next_compare_data; // zero or one

	// guard false issues nothing, so the register keeps its value
	always_comb
	begin
		next_compare_write = issue_valid && is_compare_op && guard_true;
		next_compare_dest = compare_dest;
		next_compare_data = compare_data;
		if (next_compare_write)
		begin
			next_compare_dest = issue_dest;
			if ($signed(first_source) >= $signed(second_source))
				next_compare_data = 32'h00000001;
			else
				next_compare_data = 32'h00000000;
		end
	end

	// register the compare result
	always_ff @(posedge clock or negedge reset_sync_n)
	begin
		if (!reset_sync_n)
		begin
			compare_write <= 1'b0;
			compare_dest <= '0;
			compare_data <= 32'h00000000;
		end
		else
		begin
			compare_write <= next_compare_write;
			compare_dest <= next_compare_dest;
			compare_data <= next_compare_data;
		end
	end

	// ************************************************************
	// float stage one: capture operands
	// ************************************************************
	logic stage1_valid; // live float op in stage one
	convert_compare_pkg::float_op_t stage1_kind; // convert or probe
	logic [1:0] stage1_mode; // rounding mode in effect
	logic [31:0] stage1_source; // integer to convert
	logic [DEST_WIDTH-1:0] stage1_dest; // destination index
	logic next_stage1_valid;
	convert_compare_pkg::float_op_t next_stage1_kind;
	logic [1:0] next_stage1_mode;
	logic [31:0] next_stage1_source;
	logic [DEST_WIDTH-1:0] next_stage1_dest;

	// a false guard never enters, so it can neither write nor flag
	always_comb
	begin
		next_stage1_valid = issue_valid && is_float_op && guard_true;
		next_stage1_kind = stage1_kind;
		next_stage1_mode = stage1_mode;
		next_stage1_source = stage1_source;
		next_stage1_dest = stage1_dest;
		if (next_stage1_valid)
		begin
			next_stage1_kind = issue_kind;
			next_stage1_mode = issue_mode;
			next_stage1_source = first_source;
			next_stage1_dest = issue_dest;
		end
	end

	// register stage one
	always_ff @(posedge clock or negedge reset_sync_n)
	begin
		if (!reset_sync_n)
		begin
			stage1_valid <= 1'b0;
			stage1_kind <= convert_compare_pkg::FOP_PROBE;
			stage1_mode <= convert_compare_pkg::RM_NEAREST_EVEN;
			stage1_source <= 32'h00000000;
			stage1_dest <= '0;
		end
		else
		begin
			stage1_valid <= next_stage1_valid;
			stage1_kind <= next_stage1_kind;
			stage1_mode <= next_stage1_mode;
			stage1_source <= next_stage1_source;
			stage1_dest <= next_stage1_dest;
		end
	end

	// ************************************************************
	// float stage two: convert and round
	// ************************************************************
	logic [31:0] converted; // rounded single precision value
	logic converted_inexact; // dropped bits were nonzero

	int_to_single_round rounder
	(
		.value(stage1_source),
		.mode(stage1_mode),
		.result(converted),
		.inexact(converted_inexact)
	);

	logic stage2_valid; // live float op in stage two
	convert_compare_pkg::float_op_t stage2_kind;
	logic [31:0] stage2_value; // converted word
	logic [5:0] stage2_flags; // exception vector in status layout
	logic [DEST_WIDTH-1:0] stage2_dest;
	logic next_stage2_valid;
	convert_compare_pkg::float_op_t next_stage2_kind;
	logic [31:0] next_stage2_value;
	logic [5:0] next_stage2_flags;
	logic [DEST_WIDTH-1:0] next_stage2_dest;

	// only inexact can arise from an integer source; the rest stay zero
	always_comb
	begin
		next_stage2_valid = stage1_valid;
		next_stage2_kind = stage2_kind;
		next_stage2_value = stage2_value;
		next_stage2_flags = stage2_flags;
		next_stage2_dest = stage2_dest;
		if (stage1_valid)
		begin
			next_stage2_kind = stage1_kind;
			next_stage2_value = converted;
			next_stage2_flags = 6'h00;
			next_stage2_flags[convert_compare_pkg::EXC_INEXACT_BIT] = converted_inexact;
			next_stage2_dest = stage1_dest;
		end
	end

	// register stage two
	always_ff @(posedge clock or negedge reset_sync_n)
	begin
		if (!reset_sync_n)
		begin
			stage2_valid <= 1'b0;
			stage2_kind <= convert_compare_pkg::FOP_PROBE;
			stage2_value <= 32'h00000000;
			stage2_flags <= convert_compare_pkg::EXC_RESET;
			stage2_dest <= '0;
		end
		else
		begin
			stage2_valid <= next_stage2_valid;
			stage2_kind <= next_stage2_kind;
			stage2_value <= next_stage2_value;
			stage2_flags <= next_stage2_flags;
			stage2_dest <= next_stage2_dest;
		end
	end

	// ************************************************************
	// float stage three: write back
	// ************************************************************
	logic next_float_write;
	logic [DEST_WIDTH-1:0] next_float_dest;
	logic [31:0] next_float_data;
	logic [5:0] status_set; // our contribution to the status field

	// probes return the vector, the convert returns the float word
	always_comb
	begin
		next_float_write = stage2_valid;
		next_float_dest = float_dest;
		next_float_data = float_data;
		status_set = 6'h00;
		if (stage2_valid)
		begin
			next_float_dest = stage2_dest;
			unique case (stage2_kind)
				convert_compare_pkg::FOP_CONVERT:
				begin
					next_float_data = stage2_value;
					// same edge as the destination write
					status_set = stage2_flags;
				end
				convert_compare_pkg::FOP_PROBE:
				begin
					// status left alone for probes
					next_float_data = {26'h0000000, stage2_flags};
				end
			endcase
		end
	end

	// register the float result
	always_ff @(posedge clock or negedge reset_sync_n)
	begin
		if (!reset_sync_n)
		begin
			float_write <= 1'b0;
			float_dest <= '0;
			float_data <= 32'h00000000;
		end
		else
		begin
			float_write <= next_float_write;
			float_dest <= next_float_dest;
			float_data <= next_float_data;
		end
	end

	// ************************************************************
	// sticky status exception field
	// ************************************************************
	// other units' flags merge here, so one register holds the field
	sticky_exception_bits status_bits
	(
		.clock(clock),
		.reset_n(reset_sync_n),
		.own_set(status_set),
		.other_set(other_fp_flags),
		.write_enable(status_write),
		.write_data(status_write_data),
		.bits(exception_flags)
	);

endmodule

// *** bench/reg_file_model.sv ***
`timescale 1ns/10ps
// ************************************************************
// register file seen by the datapath write ports
// ************************************************************
module reg_file_model
#(
	parameter int DEST_WIDTH = 7
)
(
	input wire logic clock,
	input wire logic float_write,
	input wire logic [DEST_WIDTH-1:0] float_dest,
	input wire logic [31:0] float_data,
	input wire logic compare_write,
	input wire logic [DEST_WIDTH-1:0] compare_dest,
	input wire logic [31:0] compare_data
);
	// storage, preset so an unwritten entry is never mistaken for zero
	logic [31:0] regs [2**DEST_WIDTH];

	initial
	begin
		foreach (regs[i])
			regs[i] = 32'h5A5A5A5A;
	end

	// both ports may land in one cycle, so they are taken independently
	always @(posedge clock)
	begin
		if (float_write)
			regs[float_dest] <= float_data;
		if (compare_write)
			regs[compare_dest] <= compare_data;
	end
endmodule

// *** bench/int_to_float_convert_and_compare_assertions.sv ***
`timescale 1ns/10ps
// ************************************************************
// port checker for the convert and compare datapath
// ************************************************************
module convert_compare_checker
#(
	parameter int DEST_WIDTH = 7
)
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic issue_valid,
	input wire logic [7:0] issue_opcode,
	input wire logic [DEST_WIDTH-1:0] issue_dest,
	input wire logic guard_enable,
	input wire logic [31:0] guard_value,
	input wire logic [31:0] first_source,
	input wire logic [31:0] second_source,
	input wire logic [1:0] rounding_mode,
	input wire logic status_write,
	input wire logic [5:0] status_write_data,
	input wire logic [5:0] other_fp_flags,
	input wire logic float_write,
	input wire logic [DEST_WIDTH-1:0] float_dest,
	input wire logic [31:0] float_data,
	input wire logic compare_write,
	input wire logic [DEST_WIDTH-1:0] compare_dest,
	input wire logic [31:0] compare_data,
	input wire logic [5:0] exception_flags
);
	// age after release; the design's reset copy lags by two edges
	logic [1:0] age;
	logic [1:0] next_age;
	// issue decode helpers
	logic take;
	logic is_probe;
	logic is_float;

	assign take = issue_valid && (!guard_enable || guard_value[0]);
	assign is_probe = issue_opcode == convert_compare_pkg::OPC_FLOAT_FLAGS
		|| issue_opcode == convert_compare_pkg::OPC_FLOAT_RZ_FLAGS;
	assign is_float = is_probe || issue_opcode == convert_compare_pkg::OPC_FLOAT_RZ;

	// saturating age counter
	always_comb
	begin
		next_age = (age == 2'h3) ? age : age + 2'h1;
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			age <= 2'h0;
		else
			age <= next_age;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n || age != 2'h3);

	a_compare_slot: assert property (take && issue_opcode == convert_compare_pkg::OPC_GEQ |=> compare_write
		&& compare_dest == $past(issue_dest)
		&& compare_data == {31'h0, $signed($past(first_source)) >= $signed($past(second_source))})
		else $error("compare write wrong or late");
	a_float_slot: assert property (take && is_float |-> ##3 float_write && float_dest == $past(issue_dest, 3))
		else $error("float write wrong or late");
	a_guard_hold: assert property (issue_valid && guard_enable && !guard_value[0] |=> !compare_write ##2 !float_write)
		else $error("false guard still wrote");
	a_probe_layout: assert property (take && is_probe |-> ##3 float_data[31:6] == 26'h0)
		else $error("probe vector has high bits set");
	a_probe_quiet: assert property (take && is_probe ##3 (!$past(status_write) && $past(other_fp_flags) == 6'h00)
		|-> exception_flags == $past(exception_flags))
		else $error("probe changed status flags");
	a_sticky_bits: assert property (!status_write |=> (exception_flags & $past(exception_flags)) == $past(exception_flags))
		else $error("status flag dropped without write");
	a_or_merge: assert property (other_fp_flags != 6'h00 |=> (exception_flags & $past(other_fp_flags)) == $past(other_fp_flags))
		else $error("other unit flags lost");
	a_set_with_write: assert property ($rose(exception_flags[1]) && !$past(status_write) && !$past(other_fp_flags[1])
		|-> float_write)
		else $error("inexact set apart from result write");
	a_write_clear: assert property (status_write && other_fp_flags == 6'h00 ##1 !float_write
		|-> exception_flags == $past(status_write_data))
		else $error("status write not taken");
endmodule

bind int_to_float_convert_and_compare convert_compare_checker #(.DEST_WIDTH(DEST_WIDTH)) u_checker
(
	.clock(clock), .reset_n(reset_n), .issue_valid(issue_valid), .issue_opcode(issue_opcode),
	.issue_dest(issue_dest), .guard_enable(guard_enable), .guard_value(guard_value),
	.first_source(first_source), .second_source(second_source), .rounding_mode(rounding_mode),
	.status_write(status_write), .status_write_data(status_write_data), .other_fp_flags(other_fp_flags),
	.float_write(float_write), .float_dest(float_dest), .float_data(float_data),
	.compare_write(compare_write), .compare_dest(compare_dest), .compare_data(compare_data),
	.exception_flags(exception_flags)
);

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
`define CHK(what, exp, got) begin checks++; if ((got) !== (exp)) begin err_total++; $display("mismatch %s expected %h seen %h", what, exp, got); end end
module tb_top;
	// ************************************************************
	// design ports and bench state
	// ************************************************************
	logic clock = 1'b0;
	logic reset_n, issue_valid, guard_enable, status_write, float_write, compare_write;
	logic [7:0] issue_opcode;
	logic [6:0] issue_dest, float_dest, compare_dest;
	logic [31:0] guard_value, first_source, second_source, float_data, compare_data;
	logic [1:0] rounding_mode, mode_sel;
	logic [5:0] status_write_data, other_fp_flags, exception_flags;
	int err_total = 0;
	int checks = 0;
	// conversion table: sources and truncated results
	logic [31:0] src [6] = '{32'h3, 32'hFFFFFFFF, 32'hFFFFFFFD, 32'h7FFFFFFF, 32'h80000000, 32'h7FFFFFF1};
	logic [31:0] flt [6] = '{32'h40400000, 32'hBF800000, 32'hC0400000, 32'h4EFFFFFF, 32'hCF000000, 32'h4EFFFFFF};
	// compare table, signed edge cases
	logic [31:0] ca [4] = '{32'h3, 32'h1000, 32'h80000000, 32'h80000000};
	logic [31:0] cb [4] = '{32'h4, 32'h100, 32'h4, 32'h80000000};

	always #2.5 clock = ~clock;

	int_to_float_convert_and_compare #(.DEST_WIDTH(7)) DUT
	(
		.clock(clock), .reset_n(reset_n), .issue_valid(issue_valid), .issue_opcode(issue_opcode),
		.issue_dest(issue_dest), .guard_enable(guard_enable), .guard_value(guard_value),
		.first_source(first_source), .second_source(second_source), .rounding_mode(rounding_mode),
		.status_write(status_write), .status_write_data(status_write_data), .other_fp_flags(other_fp_flags),
		.float_write(float_write), .float_dest(float_dest), .float_data(float_data),
		.compare_write(compare_write), .compare_dest(compare_dest), .compare_data(compare_data),
		.exception_flags(exception_flags)
	);

	reg_file_model #(.DEST_WIDTH(7)) rf
	(
		.clock(clock), .float_write(float_write), .float_dest(float_dest), .float_data(float_data),
		.compare_write(compare_write), .compare_dest(compare_dest), .compare_data(compare_data)
	);

	// ************************************************************
	// access tasks
	// ************************************************************
	// one op per edge; g bit1 is guard present, bit0 its lsb, upper guard bits junk
	task automatic issue(input logic [7:0] opc, input logic [31:0] a, input logic [31:0] b,
		input logic [6:0] dest, input logic [1:0] g);
		@(posedge clock);
		issue_valid <= 1'b1;
		issue_opcode <= opc;
		first_source <= a;
		second_source <= b;
		issue_dest <= dest;
		guard_enable <= g[1];
		guard_value <= {31'h2AAAAAAA, g[0]};
		rounding_mode <= mode_sel;
	endtask

	// drop the issue line and let the fixed three-cycle pipe drain
	task automatic settle();
		@(posedge clock);
		issue_valid <= 1'b0;
		repeat (5) @(posedge clock);
	endtask

	// explicit status write, other units may set bits in the same cycle
	task automatic status(input logic [5:0] d, input logic [5:0] o);
		@(posedge clock);
		status_write <= 1'b1;
		status_write_data <= d;
		other_fp_flags <= o;
		@(posedge clock);
		status_write <= 1'b0;
		other_fp_flags <= 6'h00;
		@(posedge clock);
	endtask

	task automatic expect_reg(input string what, input logic [6:0] idx, input logic [31:0] exp);
		`CHK(what, exp, rf.regs[idx])
	endtask

	task automatic done(input string name);
		$display("test %s finished, mismatches %0d", name, err_total);
	endtask

	task automatic conclude();
		$display("comparisons %0d, mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// hang guard
	initial
	begin
		repeat (20000) @(posedge clock);
		err_total++;
		conclude();
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		{reset_n, issue_valid, guard_enable, status_write} = 4'h0;
		{issue_opcode, issue_dest, guard_value, first_source, second_source} = '0;
		{rounding_mode, status_write_data, other_fp_flags} = '0;
		mode_sel = 2'h2;
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		repeat (3) @(posedge clock);
		`CHK("flags after reset", 6'h00, exception_flags)
		// truncating ops back to back while the status mode is toward +inf
		for (int i = 0; i < 6; i++)
		begin
			issue(convert_compare_pkg::OPC_FLOAT_RZ, src[i], 32'h0, 7'(i), 2'h0);
			issue(convert_compare_pkg::OPC_FLOAT_RZ_FLAGS, src[i], 32'h0, 7'(8 + i), 2'h3);
		end
		settle();
		for (int i = 0; i < 6; i++)
		begin
			expect_reg("rz value", 7'(i), flt[i]);
			expect_reg("rz flags", 7'(8 + i), (i == 3 || i == 5) ? 32'h2 : 32'h0);
		end
		`CHK("status after rz", 6'h02, exception_flags)
		done("truncating");
		// status-mode probe in every rounding mode
		status(6'h00, 6'h00);
		for (int m = 0; m < 4; m++)
		begin
			mode_sel = 2'(m);
			issue(convert_compare_pkg::OPC_FLOAT_FLAGS, 32'h7FFFFFF1, 32'h0, 7'(16 + m), 2'h0);
			issue(convert_compare_pkg::OPC_FLOAT_FLAGS, 32'h80000000, 32'h0, 7'(20 + m), 2'h3);
		end
		settle();
		for (int m = 0; m < 4; m++)
		begin
			expect_reg("probe inexact", 7'(16 + m), 32'h2);
			expect_reg("probe exact", 7'(20 + m), 32'h0);
		end
		`CHK("status after probes", 6'h00, exception_flags)
		done("probe");
		// signed compare table
		for (int i = 0; i < 4; i++)
			issue(convert_compare_pkg::OPC_GEQ, ca[i], cb[i], 7'(32 + i), 2'h3);
		settle();
		for (int i = 0; i < 4; i++)
			expect_reg("compare", 7'(32 + i), {31'h0, i[0]});
		done("compare");
		// false guard keeps destinations and status
		issue(convert_compare_pkg::OPC_GEQ, 32'h1000, 32'h100, 7'h28, 2'h0);
		issue(convert_compare_pkg::OPC_FLOAT_RZ, 32'h3, 32'h0, 7'h29, 2'h3);
		settle();
		status(6'h00, 6'h00);
		issue(convert_compare_pkg::OPC_GEQ, 32'h3, 32'h4, 7'h28, 2'h2);
		issue(convert_compare_pkg::OPC_FLOAT_RZ, 32'h7FFFFFFF, 32'h0, 7'h29, 2'h2);
		settle();
		expect_reg("guarded compare", 7'h28, 32'h1);
		expect_reg("guarded convert", 7'h29, 32'h40400000);
		`CHK("guarded status", 6'h00, exception_flags)
		done("guard");
		// convert inexact lands with another unit's flag in one cycle
		issue(convert_compare_pkg::OPC_FLOAT_RZ, 32'h7FFFFFFF, 32'h0, 7'h2C, 2'h0);
		@(posedge clock);
		issue_valid <= 1'b0;
		// the other unit's flag is sampled at the edge that writes the result
		@(posedge clock);
		other_fp_flags <= 6'h20;
		@(posedge clock);
		other_fp_flags <= 6'h00;
		@(posedge clock);
		`CHK("merged status", 6'h22, exception_flags)
		status(6'h01, 6'h10);
		`CHK("write with set", 6'h11, exception_flags)
		expect_reg("merged convert", 7'h2C, 32'h4EFFFFFF);
		status(6'h00, 6'h00);
		`CHK("write clear", 6'h00, exception_flags)
		done("status");
		conclude();
	end
endmodule
